// ### seg_addr_gen.sv
// Segmented address generator and flag unit with an Avalon-MM slave.
// Assumes one clock at 25 MHz, software drives addresses and ALU events.
//
// Function
// - Sign flag bit 7 copies the result's top bit.
// - Trap flag bit 8 raises a step interrupt after an instruction, then clears.
// - Maskable requests are taken only while interrupt enable bit 9 is set.
// - Direction bit 10 set decrements string indexes, clear increments them.
// - Overflow bit 11 set when a signed result does not fit.
// - A segment spans up to 64K bytes from base and 16-bit offset.
// - Physical address is segment base shifted left four plus the offset.
// - Four 16-bit segment bases: code, data, stack, extra.
// - Prefetch and immediate fetches always use the code segment.
// - Stack operations and frame base references use the stack segment.
// - String references through the destination index use the extra segment unless the frame base is also used.
// - All other data references use the data segment.
// - An override prefix replaces the implicit segment choice except for code references.
// - Offset sums displacement, a base register and an index register.
// - Carry out of the 16-bit offset sum is dropped.
// - An 8-bit displacement is sign-extended to 16 bits first.
// - Direct mode offset is the displacement alone.
// - Register indirect offset is one of four address registers.
// - Based mode adds displacement and a base register.
// - Indexed mode adds displacement and an index register.
// - Based indexed mode adds one base and one index register.
// - Based indexed with displacement adds base, index and displacement.
// - Zero flag bit 6 set when the result is zero.
// - Carry flag bit 0 set on carry out or borrow into the top bit.
//
// The register addresses and the Avalon-MM register port were chosen for this implementation.
`timescale 1ns/1ns
module seg_addr_gen (
   input wire logic clk,
   input wire logic nrst,
   input wire logic [7:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   output logic [31:0] readdata,
   output logic waitrequest,
   output logic [seg_addr_pkg::PHYS_W-1:0] phys_addr,
   output logic [15:0] flags_word,
   output logic step_irq,
   output logic vector_irq
);
   import seg_addr_pkg::*;

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   // Byte-lane merge of a write into an old value
   function automatic logic [31:0] lane_merge(logic [31:0] old, logic [31:0] nw, logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[8*i +: 8] = nw[8*i +: 8];
         end
      end
      return r;
   endfunction

   // Implicit or overridden segment for one address command
   function automatic seg_t pick_segment(addr_cmd_t c);
      logic based;
      logic frame;
      logic via_di;
      based = (c.mode == MODE_BASED) || (c.mode == MODE_BASED_IDX) || (c.mode == MODE_BASED_IDX_DISP);
      frame = (based && c.base_pick) || (c.mode == MODE_REG_IND && c.base_pick && c.idx_pick);
      via_di = ((c.mode == MODE_INDEXED || c.mode == MODE_BASED_IDX || c.mode == MODE_BASED_IDX_DISP)
               && c.idx_pick) || (c.mode == MODE_REG_IND && !c.base_pick && c.idx_pick);
      if (c.ref_kind == REF_CODE) begin
         return SEG_CODE;
      end else if (c.ovr_en) begin
         return seg_t'(c.ovr_seg);
      end else if (c.ref_kind == REF_STACK || frame) begin
         return SEG_STACK;
      end else if (c.ref_kind == REF_STRING && via_di) begin
         return SEG_EXTRA;
      end
      return SEG_DATA;
   endfunction

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   bus_st_t st_q, st_d;
   logic waitrequest_q;
   logic [31:0] readdata_q, rd_mux;
   logic [15:0] flags_q, flags_d;
   logic [15:0] gen_base_q, frame_base_q, src_index_q, dst_index_q;
   logic [15:0] alu_ctl_q, alu_res_q;
   addr_cmd_t cmd_q;
   logic calc_go_q, calc_s1_q;
   logic [15:0] offset_q;
   seg_t seg_sel_q;
   logic [PHYS_W-1:0] phys_q;
   logic step_irq_q, vector_irq_q;
   logic [15:0] seg_rd_a, seg_rd_b;

   // ------------------------------------------------------------
   // Bus decode
   // ------------------------------------------------------------
   // Writes commit on the edge that ends the low waitrequest cycle
   wire req = read | write;
   wire commit = (st_q == BUS_DONE) && write;
   wire [2:0] seg_word = address[4:2] - 3'h1;
   wire seg_t bus_seg = seg_t'(seg_word[1:0]);
   wire seg_hit = (address >= OFF_SEG_FIRST) && (address <= OFF_SEG_LAST) && (address[1:0] == 2'h0);
   wire wr_flags = commit && (address == OFF_FLAGS);
   wire wr_seg = commit && seg_hit;
   wire wr_cmd = commit && (address == OFF_ADDR_CMD);
   wire alu_go = commit && (address == OFF_OPERANDS);
   wire ev_go = commit && (address == OFF_EVENTS);
   wire str_go = ev_go && writedata[EV_STRING];
   wire [31:0] wd_flags = lane_merge({16'h0000, flags_q}, writedata, byteenable);
   wire [31:0] wd_seg = lane_merge({16'h0000, seg_rd_a}, writedata, byteenable);

   // Bus handshake sequencing
   always_comb begin
      case (st_q)
         BUS_IDLE: st_d = req ? BUS_FETCH : BUS_IDLE;
         BUS_FETCH: st_d = BUS_DONE;
         BUS_DONE: st_d = BUS_IDLE;
         default: st_d = BUS_IDLE;
      endcase
   end

   // Read data selection, unmapped reads return zero
   always_comb begin
      case (address)
         OFF_FLAGS: rd_mux = {16'h0000, flags_q};
         OFF_GEN_BASE: rd_mux = {16'h0000, gen_base_q};
         OFF_FRAME_BASE: rd_mux = {16'h0000, frame_base_q};
         OFF_SRC_INDEX: rd_mux = {16'h0000, src_index_q};
         OFF_DST_INDEX: rd_mux = {16'h0000, dst_index_q};
         OFF_ADDR_CMD: rd_mux = cmd_q;
         OFF_OFFSET: rd_mux = {16'h0000, offset_q};
         OFF_PHYS: rd_mux = {12'h000, phys_q};
         OFF_ALU_CTL: rd_mux = {16'h0000, alu_ctl_q};
         OFF_ALU_RESULT: rd_mux = {16'h0000, alu_res_q};
         OFF_EVENTS: rd_mux = {30'h0, vector_irq_q, step_irq_q};
         default: rd_mux = seg_hit ? {16'h0000, seg_rd_a} : 32'h00000000;
      endcase
   end

   // Bus state, waitrequest and read data
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         st_q <= BUS_IDLE;
         waitrequest_q <= 1'b1;
         readdata_q <= 32'h00000000;
      end else begin
         st_q <= st_d;
         waitrequest_q <= (st_d != BUS_DONE);
         if (st_q == BUS_FETCH) begin
            readdata_q <= rd_mux;
         end
      end
   end

   // ------------------------------------------------------------
   // Segment bases
   // ------------------------------------------------------------
   // Port A serves the bus, port B serves address generation
   seg_base_bank u_bank (
      .clk(clk),
      .nrst(nrst),
      .wr_en(wr_seg),
      .wr_idx(bus_seg),
      .wr_data(wd_seg[15:0]),
      .rd_a_idx(bus_seg),
      .rd_a_q(seg_rd_a),
      .rd_b_idx(pick_segment(cmd_q)),
      .rd_b_q(seg_rd_b)
   );

   // ------------------------------------------------------------
   // ALU flag evaluation
   // ------------------------------------------------------------
   // Byte operands are moved to the top so bit 15 is always the sign
   wire sub = alu_ctl_q[ALU_SUB];
   wire bmode = alu_ctl_q[ALU_BYTE];
   wire [15:0] op_a = bmode ? {writedata[7:0], 8'h00} : writedata[15:0];
   wire [15:0] op_b = bmode ? {writedata[23:16], 8'h00} : writedata[31:16];
   wire [16:0] sum17 = sub ? ({1'b0, op_a} - {1'b0, op_b}) : ({1'b0, op_a} + {1'b0, op_b});
   wire [15:0] r16 = sum17[15:0];
   wire sign_in = sub ? (op_a[15] ^ op_b[15]) : ~(op_a[15] ^ op_b[15]);
   alu_out_t alu_o;
   assign alu_o.res = bmode ? {8'h00, r16[15:8]} : r16;
   assign alu_o.cf = sum17[16];
   assign alu_o.pf = ~^(bmode ? r16[15:8] : r16[7:0]);
   assign alu_o.zf = (r16 == 16'h0000);
   assign alu_o.sf = r16[15];
   assign alu_o.of = sign_in & (r16[15] ^ op_a[15]);

   // Flag word next value; bus writes and ALU events never share a cycle
   always_comb begin
      flags_d = flags_q;
      if (wr_flags) begin
         flags_d = wd_flags[15:0] & FLAGS_MASK;
      end else if (alu_go) begin
         flags_d[CARRY_BIT] = alu_o.cf;
         flags_d[PARITY_BIT] = alu_o.pf;
         flags_d[ZERO_BIT] = alu_o.zf;
         flags_d[SIGN_BIT] = alu_o.sf;
         flags_d[OVF_BIT] = alu_o.of;
      end else if (ev_go && writedata[EV_STEP] && flags_q[TRAP_BIT]) begin
         flags_d[TRAP_BIT] = 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Events and pending interrupts
   // ------------------------------------------------------------
   // A set in the same write as its clear wins
   wire step_set = ev_go && writedata[EV_STEP] && flags_q[TRAP_BIT];
   wire irq_set = ev_go && writedata[EV_IRQ] && flags_q[IEN_BIT];
   wire step_clr = ev_go && writedata[EV_CLR_STEP];
   wire irq_clr = ev_go && writedata[EV_CLR_IRQ];
   wire [15:0] str_step = writedata[EV_WORD] ? STEP_WORD : STEP_BYTE;

   // Flags, pending interrupts, ALU result
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         flags_q <= FLAGS_RESET;
         step_irq_q <= 1'b0;
         vector_irq_q <= 1'b0;
         alu_ctl_q <= REG_RESET;
         alu_res_q <= REG_RESET;
      end else begin
         flags_q <= flags_d;
         step_irq_q <= step_set | (step_irq_q & ~step_clr);
         vector_irq_q <= irq_set | (vector_irq_q & ~irq_clr);
         if (commit && address == OFF_ALU_CTL) begin
            alu_ctl_q <= writedata[15:0];
         end
         if (alu_go) begin
            alu_res_q <= alu_o.res;
         end
      end
   end

   // Address registers; string steps follow the direction flag
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         gen_base_q <= REG_RESET;
         frame_base_q <= REG_RESET;
         src_index_q <= REG_RESET;
         dst_index_q <= REG_RESET;
      end else begin
         if (commit && address == OFF_GEN_BASE) begin
            gen_base_q <= writedata[15:0];
         end
         if (commit && address == OFF_FRAME_BASE) begin
            frame_base_q <= writedata[15:0];
         end
         if (commit && address == OFF_SRC_INDEX) begin
            src_index_q <= writedata[15:0];
         end else if (str_go) begin
            src_index_q <= flags_q[DIR_BIT] ? src_index_q - str_step : src_index_q + str_step;
         end
         if (commit && address == OFF_DST_INDEX) begin
            dst_index_q <= writedata[15:0];
         end else if (str_go) begin
            dst_index_q <= flags_q[DIR_BIT] ? dst_index_q - str_step : dst_index_q + str_step;
         end
      end
   end

   // ------------------------------------------------------------
   // Effective offset and physical address
   // ------------------------------------------------------------
   // Element selection; sums wrap within 16 bits
   wire [15:0] disp_ext = cmd_q.disp_byte ? {{8{cmd_q.disp[7]}}, cmd_q.disp[7:0]} : cmd_q.disp;
   wire [15:0] base_val = cmd_q.base_pick ? frame_base_q : gen_base_q;
   wire [15:0] idx_val = cmd_q.idx_pick ? dst_index_q : src_index_q;
   wire [15:0] ind_base = cmd_q.idx_pick ? frame_base_q : gen_base_q;
   wire [15:0] ind_val = cmd_q.base_pick ? ind_base : idx_val;
   wire [15:0] off_based = disp_ext + base_val;
   wire [15:0] off_indexed = disp_ext + idx_val;
   wire [15:0] off_bi = base_val + idx_val;
   wire [15:0] off_bid = off_bi + disp_ext;
   wire [15:0] eff_off = (cmd_q.mode == MODE_REG_IND) ? ind_val :
                         (cmd_q.mode == MODE_BASED) ? off_based :
                         (cmd_q.mode == MODE_INDEXED) ? off_indexed :
                         (cmd_q.mode == MODE_BASED_IDX) ? off_bi :
                         (cmd_q.mode == MODE_BASED_IDX_DISP) ? off_bid : disp_ext;
   wire [PHYS_W-1:0] seg_shift = {seg_rd_b, {SEG_SHIFT{1'b0}}};
   wire [PHYS_W-1:0] phys_sum = seg_shift + {{SEG_SHIFT{1'b0}}, offset_q};

   // Three-stage command pipe: command, offset and segment, physical address
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cmd_q <= '0;
         calc_go_q <= 1'b0;
         calc_s1_q <= 1'b0;
         offset_q <= REG_RESET;
         seg_sel_q <= SEG_CODE;
         phys_q <= '0;
      end else begin
         calc_go_q <= wr_cmd;
         calc_s1_q <= calc_go_q;
         if (wr_cmd) begin
            cmd_q <= lane_merge(cmd_q, writedata, byteenable);
         end
         if (calc_go_q) begin
            offset_q <= eff_off;
            seg_sel_q <= pick_segment(cmd_q);
         end
         if (calc_s1_q) begin
            phys_q <= phys_sum;
         end
      end
   end

   // Outputs straight from registers
   assign readdata = readdata_q;
   assign waitrequest = waitrequest_q;
   assign phys_addr = phys_q;
   assign flags_word = flags_q;
   assign step_irq = step_irq_q;
   assign vector_irq = vector_irq_q;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   sequence s_cmd_issue;
      calc_go_q;
   endsequence
   sequence s_phys_stage;
      calc_go_q ##1 calc_s1_q;
   endsequence

   sign_follows_a: assert property (alu_go && !bmode |=> flags_q[SIGN_BIT] == alu_res_q[15])
      else $error("sign flag differs from result top bit");
   trap_step_a: assert property (step_set |=> step_irq_q && !flags_q[TRAP_BIT])
      else $error("trap did not raise step interrupt and clear");
   irq_masked_a: assert property (ev_go && writedata[EV_IRQ] && !flags_q[IEN_BIT] && !vector_irq_q
      |=> !vector_irq_q)
      else $error("masked request was taken");
   dir_down_a: assert property (str_go && flags_q[DIR_BIT]
      |=> dst_index_q == $past(dst_index_q) - ($past(writedata[EV_WORD]) ? STEP_WORD : STEP_BYTE))
      else $error("string index did not decrement");
   ovf_edge_a: assert property (alu_go && !sub && !bmode && op_a == 16'h7fff && op_b == 16'h0001
      |=> flags_q[OVF_BIT] && flags_q[SIGN_BIT] && !flags_q[CARRY_BIT])
      else $error("signed overflow not flagged");
   phys_form_a: assert property (s_phys_stage
      |=> phys_q == PHYS_W'({$past(seg_rd_b), 4'h0} + {4'h0, $past(offset_q)}))
      else $error("physical address mismatch");
   code_fetch_a: assert property (s_cmd_issue ##0 cmd_q.ref_kind == REF_CODE
      |=> seg_sel_q == SEG_CODE)
      else $error("fetch did not use code segment");
   seg_override_a: assert property (s_cmd_issue ##0 (cmd_q.ovr_en && cmd_q.ref_kind != REF_CODE)
      |=> seg_sel_q == seg_t'($past(cmd_q.ovr_seg)))
      else $error("override segment ignored");
   disp_extend_a: assert property (s_cmd_issue ##0 (cmd_q.mode == MODE_DIRECT && cmd_q.disp_byte)
      |=> offset_q == {{8{$past(cmd_q.disp[7])}}, $past(cmd_q.disp[7:0])})
      else $error("short displacement not sign extended");
   zero_flag_a: assert property (alu_go |=> flags_q[ZERO_BIT] == (alu_res_q == 16'h0000))
      else $error("zero flag wrong");
   borrow_flag_a: assert property (alu_go && sub && !bmode && op_a < op_b |=> flags_q[CARRY_BIT])
      else $error("borrow not flagged");
   bus_answer_a: assert property (req && st_q == BUS_IDLE |-> ##2 !waitrequest_q ##1 waitrequest_q)
      else $error("bus answer latency wrong");
endmodule

// ### seg_addr_pkg.sv
// Package: offsets, field layout, flag positions, types for the address generator.
// Assumes a 32-bit Avalon-MM register bus with byte addresses.
package seg_addr_pkg;

   // ------------------------------------------------------------
   // Register byte offsets
   // ------------------------------------------------------------
   localparam logic [7:0] OFF_FLAGS = 8'h00;
   localparam logic [7:0] OFF_SEG_FIRST = 8'h04;
   localparam logic [7:0] OFF_SEG_LAST = 8'h10;
   localparam logic [7:0] OFF_GEN_BASE = 8'h14;
   localparam logic [7:0] OFF_FRAME_BASE = 8'h18;
   localparam logic [7:0] OFF_SRC_INDEX = 8'h1c;
   localparam logic [7:0] OFF_DST_INDEX = 8'h20;
   localparam logic [7:0] OFF_ADDR_CMD = 8'h24;
   localparam logic [7:0] OFF_OFFSET = 8'h28;
   localparam logic [7:0] OFF_PHYS = 8'h2c;
   localparam logic [7:0] OFF_OPERANDS = 8'h30;
   localparam logic [7:0] OFF_ALU_CTL = 8'h34;
   localparam logic [7:0] OFF_ALU_RESULT = 8'h38;
   localparam logic [7:0] OFF_EVENTS = 8'h3c;

   // ------------------------------------------------------------
   // Flag word layout and reset values
   // ------------------------------------------------------------
   localparam int CARRY_BIT = 0;
   localparam int PARITY_BIT = 2;
   localparam int ZERO_BIT = 6;
   localparam int SIGN_BIT = 7;
   localparam int TRAP_BIT = 8;
   localparam int IEN_BIT = 9;
   localparam int DIR_BIT = 10;
   localparam int OVF_BIT = 11;
   localparam logic [15:0] FLAGS_RESET = 16'h0000;
   localparam logic [15:0] FLAGS_MASK = 16'h0fd5;
   localparam logic [15:0] REG_RESET = 16'h0000;

   // Event register bits, ALU control bits
   localparam int EV_STEP = 0;
   localparam int EV_IRQ = 1;
   localparam int EV_STRING = 2;
   localparam int EV_WORD = 3;
   localparam int EV_CLR_STEP = 8;
   localparam int EV_CLR_IRQ = 9;
   localparam int ALU_SUB = 0;
   localparam int ALU_BYTE = 1;

   // Address arithmetic
   localparam int SEG_SHIFT = 4;
   localparam int PHYS_W = 20;
   localparam logic [15:0] STEP_BYTE = 16'h0001;
   localparam logic [15:0] STEP_WORD = 16'h0002;

   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef enum logic [1:0] {SEG_CODE = 2'h0, SEG_DATA = 2'h1, SEG_STACK = 2'h2, SEG_EXTRA = 2'h3} seg_t;
   typedef enum logic [1:0] {REF_CODE = 2'h0, REF_STACK = 2'h1, REF_STRING = 2'h2, REF_DATA = 2'h3} ref_t;
   typedef enum logic [2:0] {
      MODE_DIRECT = 3'h0, MODE_REG_IND = 3'h1, MODE_BASED = 3'h2,
      MODE_INDEXED = 3'h3, MODE_BASED_IDX = 3'h4, MODE_BASED_IDX_DISP = 3'h5
   } mode_t;
   typedef enum logic [2:0] {BUS_IDLE = 3'b001, BUS_FETCH = 3'b010, BUS_DONE = 3'b100} bus_st_t;

   // Address command word, bit 31 down to 0
   typedef struct packed {
      logic [4:0] spare;
      logic [1:0] ovr_seg;
      logic ovr_en;
      logic [1:0] ref_kind;
      logic disp_byte;
      logic idx_pick;
      logic base_pick;
      logic [2:0] mode;
      logic [15:0] disp;
   } addr_cmd_t;

   // Outcome of one ALU operation
   typedef struct packed {
      logic [15:0] res;
      logic cf;
      logic pf;
      logic zf;
      logic sf;
      logic of;
   } alu_out_t;

endpackage

// ### seg_base_bank.sv
// Four segment base registers with two registered read ports.
// Assumes one write per cycle from the bus side.
`timescale 1ns/1ns
module seg_base_bank (
   input wire logic clk,
   input wire logic nrst,
   input wire logic wr_en,
   input wire seg_addr_pkg::seg_t wr_idx,
   input wire logic [15:0] wr_data,
   input wire seg_addr_pkg::seg_t rd_a_idx,
   output logic [15:0] rd_a_q,
   input wire seg_addr_pkg::seg_t rd_b_idx,
   output logic [15:0] rd_b_q
);
   import seg_addr_pkg::*;

   logic [15:0] base_q [4];

   // ------------------------------------------------------------
   // Storage
   // ------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_seg
         // One base per segment
         always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
               base_q[g] <= REG_RESET;
            end else if (wr_en && (wr_idx == seg_t'(g))) begin
               base_q[g] <= wr_data;
            end
         end
      end
   endgenerate

   // Registered read ports
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rd_a_q <= REG_RESET;
         rd_b_q <= REG_RESET;
      end else begin
         rd_a_q <= base_q[rd_a_idx];
         rd_b_q <= base_q[rd_b_idx];
      end
   end
endmodule

// ### testbench.sv
// Self-checking bench for the segmented address generator and flag unit.
// Assumes seg_addr_pkg is compiled first and the slave answers within a bounded wait.
`timescale 1ns/1ns
module testbench;
   import seg_addr_pkg::*;
   // ----------------------------------------
   // Signals and counters
   // ----------------------------------------
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic [7:0] address = 8'h00;
   logic read = 1'b0;
   logic write = 1'b0;
   logic [31:0] writedata = 32'h0;
   logic [3:0] byteenable = 4'hf;
   logic [31:0] readdata;
   logic waitrequest;
   logic [PHYS_W-1:0] phys_addr;
   logic [15:0] flags_word;
   logic step_irq;
   logic vector_irq;
   logic [31:0] rv;
   int error_cnt = 0;
   int total_checks = 0;
   localparam logic [15:0] SETV [8] = '{16'h1000, 16'h2000, 16'h3000, 16'hffff,
                                        16'h0100, 16'h0200, 16'h0010, 16'hfff0};

   seg_addr_gen i_dut (.clk(clk), .nrst(nrst), .address(address), .read(read), .write(write),
      .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
      .phys_addr(phys_addr), .flags_word(flags_word), .step_irq(step_irq), .vector_irq(vector_irq));

   // Free running 25 MHz clock
   initial begin
      forever #20 clk = ~clk;
   end

   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   // Verdict and end of run
   task close_out;
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // Value comparison
   task chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   // One Avalon access, held until waitrequest is sampled low
   task xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      address <= a;
      writedata <= d;
      read <= ~wr;
      write <= wr;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (waitrequest !== 1'b0 && n < 50);
      rv = readdata;
      read <= 1'b0;
      write <= 1'b0;
      if (n >= 50) begin
         error_cnt++;
         close_out;
      end
   endtask

   // Let internal effects land, sample mid-cycle
   task settle;
      repeat (3) @(posedge clk);
      @(negedge clk);
   endtask

   // Address command, then offset and physical address
   task agen(input logic [31:0] c, input logic [31:0] eo, input logic [19:0] ep);
      xfer(1'b1, OFF_ADDR_CMD, c);
      settle;
      xfer(1'b0, OFF_OFFSET, 32'h0);
      chk(rv, eo);
      xfer(1'b0, OFF_PHYS, 32'h0);
      chk(rv, {12'h000, ep});
      chk(phys_addr, ep);
   endtask

   // ALU operation, result and {overflow, sign, zero, carry}
   task alu(input logic [31:0] ctl, input logic [31:0] ops, input logic [31:0] m, input logic [31:0] r,
            input logic [3:0] f);
      xfer(1'b1, OFF_ALU_CTL, ctl);
      xfer(1'b1, OFF_OPERANDS, ops);
      settle;
      xfer(1'b0, OFF_ALU_RESULT, 32'h0);
      chk(rv & m, r);
      chk({flags_word[OVF_BIT], flags_word[SIGN_BIT], flags_word[ZERO_BIT], flags_word[CARRY_BIT]}, f);
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   // Reset value of the flag word, unmapped read
   task t_reset;
      xfer(1'b0, OFF_FLAGS, 32'h0);
      chk(rv, {16'h0000, FLAGS_RESET});
      chk({phys_addr, step_irq, vector_irq}, 32'h0);
      xfer(1'b0, 8'h40, 32'h0);
      chk(rv, 32'h0);
   endtask

   // Every addressing mode and segment choice
   task t_agen;
      for (int i = 0; i < 8; i++) begin
         xfer(1'b1, OFF_SEG_FIRST + 8'(4 * i), {16'h0000, SETV[i]});
      end
      agen(32'h00001234, 32'h1234, 20'h11234);
      agen(32'h00d10000, 32'hfff0, 20'h2fff0);
      agen(32'h00ea0080, 32'h0180, 20'h30180);
      agen(32'h00930020, 32'h0010, 20'h00000);
      agen(32'h00c40000, 32'h0110, 20'h20110);
      agen(32'h05c51000, 32'h1110, 20'h31110);
      agen(32'h00c90000, 32'h0100, 20'h20100);
      agen(32'h00e00085, 32'hff85, 20'h2ff85);
      agen(32'h00410000, 32'h0010, 20'h30010);
   endtask

   // Flag results of add, subtract and byte add
   task t_alu;
      alu(32'h0, 32'h00017fff, 32'hffff, 32'h8000, 4'b1100);
      alu(32'h1, 32'h00010000, 32'hffff, 32'hffff, 4'b0101);
      alu(32'h2, 32'h00800080, 32'h00ff, 32'h0000, 4'b1011);
   endtask

   // Single step and maskable request
   task t_events;
      xfer(1'b1, OFF_FLAGS, 32'h100);
      xfer(1'b1, OFF_EVENTS, 32'h1);
      settle;
      chk(step_irq, 1'b1);
      chk(flags_word[TRAP_BIT], 1'b0);
      xfer(1'b1, OFF_FLAGS, 32'h0);
      xfer(1'b1, OFF_EVENTS, 32'h2);
      settle;
      chk(vector_irq, 1'b0);
      xfer(1'b1, OFF_FLAGS, 32'h200);
      xfer(1'b1, OFF_EVENTS, 32'h2);
      settle;
      chk(vector_irq, 1'b1);
      xfer(1'b0, OFF_EVENTS, 32'h0);
      chk(rv, 32'h3);
      xfer(1'b1, OFF_EVENTS, 32'h300);
      settle;
      chk({step_irq, vector_irq}, 2'b00);
   endtask

   // String steps down by words, then up by bytes
   task t_dir;
      xfer(1'b1, OFF_FLAGS, 32'h400);
      xfer(1'b1, OFF_EVENTS, 32'hc);
      settle;
      xfer(1'b0, OFF_SRC_INDEX, 32'h0);
      chk(rv, 32'h000e);
      xfer(1'b1, OFF_FLAGS, 32'h0);
      xfer(1'b1, OFF_EVENTS, 32'h4);
      settle;
      xfer(1'b0, OFF_DST_INDEX, 32'h0);
      chk(rv, 32'hffef);
      byteenable <= 4'h1;
      xfer(1'b1, OFF_FLAGS, 32'h0fff);
      byteenable <= 4'hf;
      xfer(1'b0, OFF_FLAGS, 32'h0);
      chk(rv, 32'h00d5);
   endtask

   // Main sequence
   initial begin
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      t_reset;
      t_agen;
      t_alu;
      t_events;
      t_dir;
      close_out;
   end
endmodule
